// ---- src/ssf_regs.vh ----
// Register offsets, field positions, reset values and timing constants
// for the servo status flag block. Assumes a 32-bit AXI4-Lite bus.
`ifndef SSF_REGS_VH
`define SSF_REGS_VH
// Byte offsets
`define SSF_CTRL 8'h00
`define SSF_DONE_THR 8'h04
`define SSF_DONE_HOLD 8'h08
`define SSF_NEAR_THR 8'h0c
`define SSF_SPD_WID 8'h10
`define SSF_BRK_DLY 8'h14
`define SSF_BRK_SPD 8'h18
`define SSF_BRK_WAIT 8'h1c
`define SSF_TRQ_THR 8'h20
`define SSF_TRQ_WID 8'h24
`define SSF_ZPW 8'h28
`define SSF_ZERO_SPD 8'h2c
`define SSF_GEAR2 8'h30
`define SSF_GEAR3 8'h34
`define SSF_GEAR4 8'h38
`define SSF_STATUS 8'h3c
`define SSF_ZPW_ACT 8'h40
// Control fields
`define SSF_CTRL_DMODE_LSB 0
`define SSF_CTRL_CMODE_LSB 4
// Status bit positions
`define SSF_ST_DONE 0
`define SSF_ST_NEAR 1
`define SSF_ST_TRQ 2
`define SSF_ST_SPD 3
`define SSF_ST_ZERO 4
`define SSF_ST_CLR 5
`define SSF_ST_BRAKE 6
`define SSF_ST_OFF 7
// Reset values
`define SSF_DEF_DONE_THR 16'h0064
`define SSF_DEF_DONE_HOLD 16'h0001
`define SSF_DEF_NEAR_THR 16'hffff
`define SSF_DEF_SPD_WID 16'h0064
`define SSF_DEF_BRK_DLY 16'h000a
`define SSF_DEF_BRK_SPD 16'h0064
`define SSF_DEF_BRK_WAIT 16'h000a
`define SSF_DEF_TRQ_THR 16'h03e8
`define SSF_DEF_TRQ_WID 16'h00c8
`define SSF_DEF_ZPW 16'h0000
`define SSF_DEF_ZERO_SPD 16'h003c
`define SSF_DEF_GEAR 32'h00000000
// Limits
`define SSF_MIN_SPD_WID 16'h000a
`define SSF_MAX_SPD_WID 16'h2328
`define SSF_MAX_MS 16'h270f
`define SSF_MAX_3000 16'h0bb8
`define SSF_MAX_ZPW 16'h0064
`define SSF_MAX_ZERO 16'h03e8
`define SSF_MAX_GEAR 32'h40000000
`define SSF_SPD_BAND 16'h000a
// Timing
`define SSF_CLK_NS 8
`define SSF_MS_NS 1000000
`endif

// ---- src/ssf_flags.v ----
// Servo status flags, positioning completion, brake timing, deviation
// clear and gear numerator registers behind an AXI4-Lite slave.
// Assumes all inputs are synchronous to i_clk; one synchronous reset.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`include "ssf_regs.vh"
`default_nettype none
module ssf_flags #(
  parameter MS_CYC = `SSF_MS_NS / `SSF_CLK_NS
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // AXI4-Lite write
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  // AXI4-Lite read
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // Drive state
  input wire signed [31:0] i_pos_dev,
  input wire signed [31:0] i_pos_cmd,
  input wire signed [31:0] i_pos_cmd_filt,
  input wire signed [15:0] i_speed_fb,
  input wire signed [15:0] i_torque_fb,
  input wire i_servo_on,
  input wire i_fault,
  input wire i_off_req,
  input wire i_restart,
  input wire i_deviation_clear_input,
  // Flags and live phase-Z width
  output reg o_position_done_flag,
  output reg o_near_flag,
  output reg o_torque_reached_flag,
  output reg o_speed_reached_flag,
  output reg o_zero_speed_flag,
  output reg o_dev_clear,
  output reg o_brake_engage,
  output reg o_servo_off,
  output reg [15:0] o_zpw
);

  // Limit a written word to its legal range
  function [31:0] lim;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    lim = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // Same for 16-bit settings, so no result bits are dropped
  function [15:0] lim16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    lim16 = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // Magnitude of a signed 32-bit value
  function [31:0] mag32;
    input [31:0] v;
    begin
      mag32 = v[31] ? (~v + 32'h00000001) : v;
    end
  endfunction

  // Magnitude of a signed 16-bit value
  function [15:0] mag16;
    input [15:0] v;
    begin
      mag16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  // Brake sequence states
  localparam [3:0] ST_RUN = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_DLY = 4'b0100;
  localparam [3:0] ST_OFF = 4'b1000;

  reg [7:0] ctrl_ff;
  reg [15:0] done_thr_ff, done_hold_ff, near_thr_ff, spd_wid_ff;
  reg [15:0] brk_dly_ff, brk_spd_ff, brk_wait_ff;
  reg [15:0] trq_thr_ff, trq_wid_ff, zpw_ff, zero_spd_ff;
  reg [31:0] gear2_ff, gear3_ff, gear4_ff;
  reg [3:0] st_ff, nxt_st;
  reg [16:0] ms_cnt_ff;
  reg ms_tick_ff;
  reg [15:0] hold_ff, brk_cnt_ff;
  wire [31:0] wd;
  wire wr_go, rd_go;
  wire [31:0] dev_abs;
  wire [15:0] spd_abs, trq_abs;
  wire [2:0] cmode;
  wire [1:0] dmode;
  wire base_ok, cond, zero_now;
  wire signed [17:0] trq_on, trq_off;
  reg [31:0] rd_val, rd_wr;
  reg rd_hit;

  // Write taken only with address and data together and no reply pending
  assign wr_go = i_awvalid & i_wvalid & ~o_bvalid;
  assign o_awready = wr_go;
  assign o_wready = wr_go;
  assign rd_go = i_arvalid & ~o_rvalid;
  assign o_arready = ~o_rvalid;
  // Strobes select lanes over the stored CTRL or GEAR2-4 value, zero for other offsets
  assign wd = {i_wstrb[3] ? i_wdata[31:24] : rd_wr[31:24],
               i_wstrb[2] ? i_wdata[23:16] : rd_wr[23:16],
               i_wstrb[1] ? i_wdata[15:8] : rd_wr[15:8],
               i_wstrb[0] ? i_wdata[7:0] : rd_wr[7:0]};

  // Current contents of CTRL or GEAR2-4 at the write address, zero elsewhere, for partial strobes
  always @* begin
    case (i_awaddr)
      `SSF_CTRL: rd_wr = {24'h000000, ctrl_ff};
      `SSF_GEAR2: rd_wr = gear2_ff;
      `SSF_GEAR3: rd_wr = gear3_ff;
      `SSF_GEAR4: rd_wr = gear4_ff;
      default: rd_wr = 32'h00000000;
    endcase
  end

  // Register writes; out-of-range values are pulled to the nearest limit
  always @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_ff <= 8'h00;
      done_thr_ff <= `SSF_DEF_DONE_THR;
      done_hold_ff <= `SSF_DEF_DONE_HOLD;
      near_thr_ff <= `SSF_DEF_NEAR_THR;
      spd_wid_ff <= `SSF_DEF_SPD_WID;
      brk_dly_ff <= `SSF_DEF_BRK_DLY;
      brk_spd_ff <= `SSF_DEF_BRK_SPD;
      brk_wait_ff <= `SSF_DEF_BRK_WAIT;
      trq_thr_ff <= `SSF_DEF_TRQ_THR;
      trq_wid_ff <= `SSF_DEF_TRQ_WID;
      zpw_ff <= `SSF_DEF_ZPW;
      zero_spd_ff <= `SSF_DEF_ZERO_SPD;
      gear2_ff <= `SSF_DEF_GEAR;
      gear3_ff <= `SSF_DEF_GEAR;
      gear4_ff <= `SSF_DEF_GEAR;
    end else if (wr_go) begin
      case (i_awaddr)
        `SSF_CTRL: ctrl_ff <= wd[7:0];
        `SSF_DONE_THR:
          done_thr_ff <= lim16(wd[15:0], 16'h0001, 16'hffff) ;
        `SSF_DONE_HOLD:
          done_hold_ff <= lim16(wd[15:0], 16'h0001, 16'hffff) ;
        `SSF_NEAR_THR:
          near_thr_ff <= lim16(wd[15:0], 16'h0001, 16'hffff) ;
        `SSF_SPD_WID: spd_wid_ff <= lim16(wd[15:0],
          `SSF_MIN_SPD_WID, `SSF_MAX_SPD_WID) ;
        `SSF_BRK_DLY: brk_dly_ff <= lim16(wd[15:0], 16'h0000,
          `SSF_MAX_MS) ;
        `SSF_BRK_SPD: brk_spd_ff <= lim16(wd[15:0], 16'h0000,
          `SSF_MAX_3000) ;
        `SSF_BRK_WAIT: brk_wait_ff <= lim16(wd[15:0], 16'h0000,
          `SSF_MAX_MS) ;
        `SSF_TRQ_THR: trq_thr_ff <= lim16(wd[15:0], 16'h0000,
          `SSF_MAX_3000) ;
        `SSF_TRQ_WID: trq_wid_ff <= lim16(wd[15:0], 16'h0000,
          `SSF_MAX_3000) ;
        `SSF_ZPW: zpw_ff <= lim16(wd[15:0], 16'h0000,
          `SSF_MAX_ZPW) ;
        `SSF_ZERO_SPD: zero_spd_ff <= lim16(wd[15:0], 16'h0000,
          `SSF_MAX_ZERO) ;
        `SSF_GEAR2: gear2_ff <= lim(wd, 32'h1, `SSF_MAX_GEAR) ;
        `SSF_GEAR3: gear3_ff <= lim(wd, 32'h1, `SSF_MAX_GEAR) ;
        `SSF_GEAR4: gear4_ff <= lim(wd, 32'h1, `SSF_MAX_GEAR) ;
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp <= (i_awaddr[1:0] != 2'b00 || i_awaddr > `SSF_GEAR4) ?
        2'b10 : 2'b00;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Read decode
  always @* begin
    rd_hit = 1'b1;
    case (i_araddr)
      `SSF_CTRL: rd_val = {24'h000000, ctrl_ff};
      `SSF_DONE_THR: rd_val = {16'h0000, done_thr_ff};
      `SSF_DONE_HOLD: rd_val = {16'h0000, done_hold_ff};
      `SSF_NEAR_THR: rd_val = {16'h0000, near_thr_ff};
      `SSF_SPD_WID: rd_val = {16'h0000, spd_wid_ff};
      `SSF_BRK_DLY: rd_val = {16'h0000, brk_dly_ff};
      `SSF_BRK_SPD: rd_val = {16'h0000, brk_spd_ff};
      `SSF_BRK_WAIT: rd_val = {16'h0000, brk_wait_ff};
      `SSF_TRQ_THR: rd_val = {16'h0000, trq_thr_ff};
      `SSF_TRQ_WID: rd_val = {16'h0000, trq_wid_ff};
      `SSF_ZPW: rd_val = {16'h0000, zpw_ff};
      `SSF_ZERO_SPD: rd_val = {16'h0000, zero_spd_ff};
      `SSF_GEAR2: rd_val = gear2_ff;
      `SSF_GEAR3: rd_val = gear3_ff;
      `SSF_GEAR4: rd_val = gear4_ff;
      `SSF_STATUS: rd_val = {24'h000000, o_servo_off, o_brake_engage,
        o_dev_clear, o_zero_speed_flag, o_speed_reached_flag,
        o_torque_reached_flag, o_near_flag, o_position_done_flag};
      `SSF_ZPW_ACT: rd_val = {16'h0000, o_zpw};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data registered; held until the master takes it
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= 2'b00;
    end else if (rd_go) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_val;
      o_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Phase-Z width only moves to the live copy on a restart pulse
  always @(posedge i_clk) begin
    if (i_rst)
      o_zpw <= `SSF_DEF_ZPW;
    else if (i_restart)
      o_zpw <= zpw_ff;
  end

  // Millisecond time base as a one-cycle enable
  always @(posedge i_clk) begin
    if (i_rst) begin
      ms_cnt_ff <= 17'h00000;
      ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff == MS_CYC[16:0] - 17'h00001) begin
      ms_cnt_ff <= 17'h00000;
      ms_tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 17'h00001;
      ms_tick_ff <= 1'b0;
    end
  end

  assign dev_abs = mag32(i_pos_dev);
  assign spd_abs = mag16(i_speed_fb);
  assign trq_abs = mag16(i_torque_fb);
  assign cmode = ctrl_ff[`SSF_CTRL_CMODE_LSB +: 3];
  assign dmode = ctrl_ff[`SSF_CTRL_DMODE_LSB +: 2];
  assign zero_now = spd_abs < zero_spd_ff;

  // Completion condition per mode; upper half adds zero speed
  assign base_ok = dev_abs < {16'h0000, done_thr_ff};
  assign cond = base_ok &
    (cmode[1:0] == 2'd0 ? 1'b1 :
     cmode[1:0] == 2'd3 ? (i_pos_cmd_filt == 32'sd0) :
     (i_pos_cmd == 32'sd0)) &
    (~cmode[2] | zero_now);

  // Torque hysteresis bounds, signed so a small threshold cannot wrap
  assign trq_on = $signed({2'b00, trq_thr_ff}) +
    $signed({2'b00, trq_wid_ff});
  assign trq_off = $signed({2'b00, trq_thr_ff}) -
    $signed({4'b0000, trq_wid_ff[15:2]});

  // Holding time: in modes 2 and 6 the flag stays up for the set ms after the condition goes
  always @(posedge i_clk) begin
    if (i_rst) begin
      hold_ff <= 16'h0000;
      o_position_done_flag <= 1'b0;
    end else if (cond) begin
      hold_ff <= done_hold_ff;
      o_position_done_flag <= 1'b1;
    end else if (cmode[1:0] == 2'd2 && hold_ff != 16'h0000) begin
      if (ms_tick_ff)
        hold_ff <= hold_ff - 16'h0001;
      o_position_done_flag <= 1'b1;
    end else begin
      hold_ff <= 16'h0000;
      o_position_done_flag <= 1'b0;
    end
  end

  // Indication flags, registered once per clock
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_near_flag <= 1'b0;
      o_zero_speed_flag <= 1'b0;
      o_speed_reached_flag <= 1'b0;
      o_torque_reached_flag <= 1'b0;
    end else begin
      o_near_flag <= dev_abs < {16'h0000, near_thr_ff};
      o_zero_speed_flag <= zero_now;
      o_speed_reached_flag <= {1'b0, spd_abs} + {1'b0, `SSF_SPD_BAND} >=
        {1'b0, spd_wid_ff};
      if ($signed({2'b00, trq_abs}) >= trq_on)
        o_torque_reached_flag <= 1'b1;
      else if ($signed({2'b00, trq_abs}) < trq_off)
        o_torque_reached_flag <= 1'b0;
    end
  end

  // Deviation clear per selected mode
  always @(posedge i_clk) begin
    if (i_rst)
      o_dev_clear <= 1'b0;
    else
      case (dmode)
        2'd0: o_dev_clear <= ~i_servo_on | i_fault;
        2'd1: o_dev_clear <= i_fault;
        2'd2: o_dev_clear <= ~i_servo_on | i_fault |
          i_deviation_clear_input;
        default: o_dev_clear <= i_deviation_clear_input;
      endcase
  end

  // Brake sequence: at rest brake first then delay; moving waits
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_RUN:
        if (i_off_req)
          nxt_st = zero_now ? ST_DLY : ST_WAIT;
      ST_WAIT:
        if (spd_abs <= brk_spd_ff || brk_cnt_ff >= brk_wait_ff)
          nxt_st = ST_OFF;
      ST_DLY:
        if (brk_cnt_ff >= brk_dly_ff)
          nxt_st = ST_OFF;
      ST_OFF:
        if (~i_off_req)
          nxt_st = ST_RUN;
      default: nxt_st = ST_RUN;
    endcase
  end

  // Brake state, ms counter and outputs
  always @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= ST_RUN;
      brk_cnt_ff <= 16'h0000;
      o_brake_engage <= 1'b0;
      o_servo_off <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (nxt_st != st_ff)
        brk_cnt_ff <= 16'h0000;
      else if (ms_tick_ff && brk_cnt_ff != 16'hffff)
        brk_cnt_ff <= brk_cnt_ff + 16'h0001;
      o_brake_engage <= nxt_st == ST_DLY || nxt_st == ST_OFF;
      o_servo_off <= nxt_st == ST_OFF;
    end
  end

endmodule
`default_nettype wire

// ---- tb/ssf_ctrl_model.sv ----
// Motion controller model: samples the flag terminals, drives clear.
// Assumes the bench asks for the clear level it wants on the input.
`default_nettype none
module ssf_ctrl_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bench side
  input wire logic i_clr_req,
  output var logic [7:0] o_seen,
  // Terminal side
  input wire logic [7:0] i_flags,
  output var logic o_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clear level moves only after an edge, one cycle behind the ask
  always @(posedge i_clk) begin
    o_clear <= i_rst ? 1'b0 : i_clr_req;
    o_seen <= i_flags;
  end
endmodule
`default_nettype wire

// ---- tb/ssf_flags_sva.sv ----
// Concurrent checks on the status flag block, bound to its ports.
// Assumes thresholds outside the control register keep reset values.
`default_nettype none
module ssf_flags_sva (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Register bus
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  input wire [31:0] i_wdata,
  input wire i_wvalid,
  input wire [1:0] o_bresp,
  input wire o_bvalid,
  input wire i_bready,
  input wire i_arvalid,
  input wire [31:0] o_rdata,
  input wire o_rvalid,
  input wire i_rready,
  // Drive state
  input wire signed [31:0] i_pos_dev,
  input wire signed [31:0] i_pos_cmd,
  input wire signed [31:0] i_pos_cmd_filt,
  input wire signed [15:0] i_speed_fb,
  input wire signed [15:0] i_torque_fb,
  input wire i_servo_on,
  input wire i_fault,
  input wire i_deviation_clear_input,
  // Flags
  input wire o_position_done_flag,
  input wire o_near_flag,
  input wire o_torque_reached_flag,
  input wire o_speed_reached_flag,
  input wire o_zero_speed_flag,
  input wire o_dev_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic [6:0] ctrl_ff;
  logic [31:0] dev_abs;
  logic [15:0] spd_abs;
  logic [15:0] trq_abs;
  logic done_c;
  logic clr_c;
  // Control mirror, caught on the same edge the slave takes it
  always @(posedge i_clk) begin
    if (i_rst)
      ctrl_ff <= 7'h00;
    else if (i_awvalid && i_wvalid && !o_bvalid && i_awaddr == 8'h00)
      ctrl_ff <= i_wdata[6:0];
  end
  // Magnitudes; the most negative code is never driven
  assign dev_abs = i_pos_dev[31] ? -i_pos_dev : i_pos_dev;
  assign spd_abs = i_speed_fb[15] ? -i_speed_fb : i_speed_fb;
  assign trq_abs = i_torque_fb[15] ? -i_torque_fb : i_torque_fb;
  // Mode conditions
  assign done_c = dev_abs < 32'h00000064 &&
    (!ctrl_ff[6] || spd_abs < 16'h003c) && (ctrl_ff[5:4] == 2'h0 ||
    (ctrl_ff[5:4] == 2'h3 ? i_pos_cmd_filt == 32'h0 : i_pos_cmd == 32'h0));
  assign clr_c = ctrl_ff[1:0] == 2'h3 ? i_deviation_clear_input :
    ctrl_ff[1:0] == 2'h1 ? i_fault : i_fault || !i_servo_on ||
    (ctrl_ff[1:0] == 2'h2 && i_deviation_clear_input);
  a_write_answer:
    assert property (i_awvalid && i_wvalid && !o_bvalid |=> o_bvalid)
    else $error("write not answered");
  a_bresp_holds:
    assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_read_answer:
    assert property (i_arvalid && !o_rvalid |=> o_rvalid)
    else $error("read not answered");
  a_rdata_holds:
    assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_done_modes:
    assert property (ctrl_ff[5:4] != 2'h2 && $stable(i_speed_fb) |=>
      o_position_done_flag == $past(done_c))
    else $error("completion flag wrong");
  a_done_hold_set:
    assert property (ctrl_ff[5:4] == 2'h2 && done_c && $stable(i_speed_fb)
      |=> o_position_done_flag)
    else $error("held completion flag not set");
  a_near_level:
    assert property (!i_rst |=>
      o_near_flag == ($past(dev_abs) < 32'h0000ffff))
    else $error("near flag wrong");
  a_zero_level:
    assert property (!i_rst |=>
      o_zero_speed_flag == ($past(spd_abs) < 16'h003c))
    else $error("zero speed flag wrong");
  a_speed_level:
    assert property (!i_rst |=> o_speed_reached_flag ==
      ($past(spd_abs) + 16'h000a >= 16'h0064))
    else $error("speed reached flag wrong");
  a_torque_set:
    assert property (trq_abs >= 16'h04b0 |=> o_torque_reached_flag)
    else $error("torque flag not set");
  a_torque_hyst:
    assert property (trq_abs < 16'h04b0 |=> o_torque_reached_flag ==
      ($past(trq_abs) >= 16'h03b6 && $past(o_torque_reached_flag)))
    else $error("torque flag hysteresis wrong");
  a_clear_modes:
    assert property (!i_rst |=> o_dev_clear == $past(clr_c))
    else $error("deviation clear wrong");
endmodule
bind ssf_flags ssf_flags_sva ssf_flags_sva_i (.*);
`default_nettype wire

// ---- tb/ssf_flags_tb.sv ----
// Self-checking bench for the status flag block over AXI4-Lite.
// Assumes ten cycles per ms and that only the tested registers change.
`default_nettype none
module ssf_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, pa;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, dm;
  logic signed [31:0] i_pos_dev, i_pos_cmd, i_pos_cmd_filt;
  logic signed [15:0] i_speed_fb, i_torque_fb;
  logic i_servo_on, i_fault, i_off_req, i_restart, i_deviation_clear_input;
  logic o_position_done_flag, o_near_flag, o_torque_reached_flag;
  logic o_speed_reached_flag, o_zero_speed_flag, o_dev_clear;
  logic o_brake_engage, o_servo_off, clr_req, tq;
  logic [15:0] o_zpw, sa, ta;
  logic [2:0] cm;
  int fail_count, n_compared, seed;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  logic [7:0] da[14] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};
  logic [15:0] dv[14] = '{16'h0064, 16'h0001, 16'hffff, 16'h0064, 16'h000a,
    16'h0064, 16'h000a, 16'h03e8, 16'h00c8, 16'h0000, 16'h003c, 16'h0000,
    16'h0000, 16'h0000};
  logic [15:0] tt[7] = '{16'h04af, 16'h04b0, 16'h03e8, 16'h03b6, 16'h03b5,
    16'hfb50, 16'hfc4b};
  ssf_flags #(.MS_CYC(10)) ssf_flags_i (.*);
  ssf_ctrl_model ssf_ctrl_model_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_clr_req(clr_req), .o_seen(), .o_clear(i_deviation_clear_input),
    .i_flags({o_servo_off, o_brake_engage, o_dev_clear, o_zero_speed_flag,
    o_speed_reached_flag, o_torque_reached_flag, o_near_flag,
    o_position_done_flag}));
  assign pa = i_pos_dev < 0 ? -i_pos_dev : i_pos_dev;
  assign sa = i_speed_fb < 0 ? -i_speed_fb : i_speed_fb;
  assign ta = i_torque_fb < 0 ? -i_torque_fb : i_torque_fb;
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic check(input string what, input logic [33:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Answer watcher: oldest note against each completed response
  always @(posedge i_clk) begin
    if (o_rvalid && i_rready)
      check("read", {o_rresp, o_rdata}, rq.pop_front());
    if (o_bvalid && i_bready)
      check("bresp", {32'h0, o_bresp}, {32'h0, wq.pop_front()});
  end
  // Bounded wait; a slave that never answers ends the run
  task automatic hs(input int w);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!(w == 0 ? o_awready && o_wready : w == 1 ? o_bvalid :
      w == 2 ? o_arready : o_rvalid) && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("ERROR handshake %0d expected 1 seen 0", w);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
    wq.push_back(r);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    hs(0);
    i_awvalid <= 1'b0;
    i_wvalid <= 1'b0;
    hs(1);
    // Late ready, so the reply has to stand a cycle
    i_bready <= 1'b1;
    @(posedge i_clk);
    i_bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    hs(2);
    i_arvalid <= 1'b0;
    hs(3);
    i_rready <= 1'b1;
    @(posedge i_clk);
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  function automatic logic dn();
    return pa < 32'h00000064 && (!cm[2] || sa < 16'h003c) &&
      (cm[1:0] == 2'h0 ||
      (cm[1:0] == 2'h3 ? i_pos_cmd_filt == 32'h0 : i_pos_cmd == 32'h0));
  endfunction
  function automatic logic [33:0] st(input logic d, b, o);
    logic c;
    c = dm == 2'h3 ? clr_req : dm == 2'h1 ? i_fault :
      i_fault || !i_servo_on || (dm == 2'h2 && clr_req);
    return {26'h0, o, b, c, sa < 16'h003c, sa + 16'h000a >= 16'h0064, tq,
      pa < 32'h0000ffff, d};
  endfunction
  // Let inputs settle, then read status; d[1] forces the done bit
  task automatic chk(input int w, input logic [1:0] d, input logic b, o);
    repeat (w) @(posedge i_clk);
    if (ta >= 16'h04b0)
      tq = 1'b1;
    else if (ta < 16'h03b6)
      tq = 1'b0;
    rd(8'h3c, st(d[1] ? d[0] : dn(), b, o));
  endtask
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'hf;
    {i_pos_cmd, i_pos_cmd_filt, i_speed_fb, i_torque_fb} = 96'h0;
    {i_fault, i_off_req, i_restart, clr_req, tq} = 5'h00;
    i_pos_dev = 32'h000003e8;
    i_servo_on = 1'b1;
    {cm, dm} = 5'h00;
    {fail_count, n_compared, seed} = {32'h0, 32'h0, 32'h2d};
    i_rst = 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 14; i++)
      rd(da[i], {18'h0, dv[i]});
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      cm = i[2:0];
      wr(8'h00, {25'h0, cm, 4'h0}, 2'h0);
      for (int k = 0; k < 6; k++) begin
        i_pos_dev <= $random(seed) % 150;
        i_pos_cmd <= $random(seed) & 32'h1;
        i_pos_cmd_filt <= $random(seed) & 32'h1;
        i_speed_fb <= 16'($random(seed) % 100);
        chk(30, 2'h0, 1'b0, 1'b0);
      end
    end
    cm = 3'h2;
    wr(8'h00, 32'h20, 2'h0);
    wr(8'h08, 32'h3, 2'h0);
    {i_pos_dev, i_pos_cmd, i_speed_fb} <= 80'h0;
    chk(30, 2'h0, 1'b0, 1'b0);
    i_pos_dev <= 32'h000003e8;
    chk(1, 2'h3, 1'b0, 1'b0);
    chk(60, 2'h2, 1'b0, 1'b0);
    $display("test completion done");
    cm = 3'h0;
    wr(8'h00, 32'h0, 2'h0);
    for (int i = 0; i < 7; i++) begin
      i_torque_fb <= tt[i];
      chk(3, 2'h0, 1'b0, 1'b0);
    end
    $display("test torque done");
    for (int i = 0; i < 4; i++) begin
      dm = i[1:0];
      wr(8'h00, {30'h0, dm}, 2'h0);
      for (int k = 0; k < 8; k++) begin
        {i_servo_on, i_fault, clr_req} <= k[2:0];
        chk(3, 2'h0, 1'b0, 1'b0);
      end
    end
    {i_servo_on, i_fault, clr_req} <= 3'h4;
    $display("test clear done");
    wr(8'h14, 32'h2, 2'h0);
    i_speed_fb <= 16'h0000;
    i_off_req <= 1'b1;
    chk(2, 2'h0, 1'b1, 1'b0);
    chk(40, 2'h0, 1'b1, 1'b1);
    i_off_req <= 1'b0;
    chk(5, 2'h0, 1'b0, 1'b0);
    i_speed_fb <= 16'h01f4;
    chk(5, 2'h0, 1'b0, 1'b0);
    i_off_req <= 1'b1;
    chk(5, 2'h0, 1'b0, 1'b0);
    i_speed_fb <= 16'h0032;
    chk(5, 2'h0, 1'b1, 1'b1);
    i_off_req <= 1'b0;
    chk(5, 2'h0, 1'b0, 1'b0);
    i_speed_fb <= 16'h01f4;
    i_off_req <= 1'b1;
    chk(120, 2'h0, 1'b1, 1'b1);
    i_off_req <= 1'b0;
    $display("test brake done");
    wr(8'h30, 32'h0, 2'h0);
    rd(8'h30, 34'h1);
    wr(8'h34, 32'h40000001, 2'h0);
    rd(8'h34, 34'h40000000);
    i_wstrb <= 4'h8;
    wr(8'h34, 32'h12345678, 2'h0);
    i_wstrb <= 4'hf;
    rd(8'h34, 34'h12000000);
    wr(8'h18, 32'h1388, 2'h0);
    rd(8'h18, 34'hbb8);
    wr(8'h28, 32'h32, 2'h0);
    rd(8'h40, 34'h0);
    i_restart <= 1'b1;
    @(posedge i_clk);
    i_restart <= 1'b0;
    rd(8'h40, 34'h32);
    rd(8'h44, {2'h2, 32'h0});
    wr(8'h3c, 32'hff, 2'h2);
    $display("test registers done");
    summarize();
  end
endmodule
`default_nettype wire
